// >>> tcm_pkg.sv
// package: register map, field layout and constants of the modulo timer core
package tcm_pkg;
   localparam logic [11:0] TCM_OFS_CTRL = 12'h000;
   localparam logic [11:0] TCM_OFS_COUNT = 12'h004;
   localparam logic [11:0] TCM_OFS_MODULO = 12'h008;
   localparam logic [11:0] TCM_OFS_IRQ_STATUS = 12'h010;
   localparam logic [11:0] TCM_OFS_IRQ_ENABLE = 12'h014;
   localparam logic [11:0] TCM_OFS_IRQ_CLEAR = 12'h018;
   localparam int TCM_CTRL_PS_LSB = 0;
   localparam int TCM_CTRL_SRC_LSB = 3;
   localparam int TCM_CTRL_DBG_LSB = 8;
   localparam int TCM_CTRL_OVF_BIT = 7;
   localparam logic [15:0] TCM_COUNT_RESET = 16'h0000;
   localparam logic [15:0] TCM_MODULO_RESET = 16'hFFFF;
   localparam logic [2:0] TCM_PS_RESET = 3'h0;
   localparam int TCM_COUNT_READ_WAITS = 2;
   localparam logic [1:0] TCM_SRC_OFF = 2'h0;
   localparam logic [1:0] TCM_SRC_INT = 2'h1;
   localparam logic [1:0] TCM_SRC_EXT = 2'h2;
   localparam logic [1:0] TCM_SRC_RSVD = 2'h3;
   typedef struct packed {
      logic [1:0] src;
      logic [2:0] ps;
      logic dbg_run;
   } tcm_ctrl_type;
endpackage

// >>> tcm_prescaler.sv
// divider: turns counting ticks into one-cycle advance pulses
`timescale 1ns/1ps
`default_nettype none
module tcm_prescaler (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clear,
   input wire logic tick,
   input wire logic [2:0] ps,
   output logic advance
);
   logic [6:0] div_q;
   logic [6:0] mask;
   logic hit;
   assign mask = 7'((8'h01 << ps) - 8'h01);
   assign hit = tick && ((div_q & mask) == mask);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 7'h00;
         advance <= 1'b0;
      end else begin
         advance <= hit;
         if (clear) begin
            div_q <= 7'h00;
         end else if (tick) begin
            div_q <= hit ? 7'h00 : 7'(div_q + 7'h01);
         end
      end
   end
endmodule
`default_nettype wire

// >>> tcm_core.sv
// top: apb slave, clock source select, counter, modulo buffer and overflow
`timescale 1ns/1ps
`default_nettype none
module tcm_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_count_clock_input,
   input wire logic debug_active,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////////
   tcm_pkg::tcm_ctrl_type ctrl_q;
   logic [1:0] src_ack_q;
   logic [15:0] count_q;
   logic [15:0] modulo_q;
   logic [15:0] mod_buf_q;
   logic mod_pend_q;
   logic ovf_q;
   logic ovf_ie_q;
   logic [1:0] wait_q;
   logic ext_s1_q;
   logic ext_s2_q;
   logic ext_s3_q;

   wire setup = psel && !penable;
   wire access = psel && penable;
   wire sel_ctrl = paddr == tcm_pkg::TCM_OFS_CTRL;
   wire sel_count = paddr == tcm_pkg::TCM_OFS_COUNT;
   wire sel_mod = paddr == tcm_pkg::TCM_OFS_MODULO;
   wire sel_st = paddr == tcm_pkg::TCM_OFS_IRQ_STATUS;
   wire sel_ie = paddr == tcm_pkg::TCM_OFS_IRQ_ENABLE;
   wire sel_clr = paddr == tcm_pkg::TCM_OFS_IRQ_CLEAR;
   wire mapped = sel_ctrl | sel_count | sel_mod | sel_st | sel_ie | sel_clr;
   wire slow_read = sel_count && !pwrite;
   wire done = access && (!slow_read || wait_q == 2'(tcm_pkg::TCM_COUNT_READ_WAITS));
   wire wr = done && pwrite;
   wire wr_ctrl = wr && sel_ctrl;
   wire wr_count = wr && sel_count;
   wire wr_mod = wr && sel_mod;
   wire [1:0] new_src = pwdata[tcm_pkg::TCM_CTRL_SRC_LSB +: 2];
   wire enabled = src_ack_q == tcm_pkg::TCM_SRC_INT || src_ack_q == tcm_pkg::TCM_SRC_EXT;
   wire ext_rise = ext_s2_q && !ext_s3_q;
   wire tick = (src_ack_q == tcm_pkg::TCM_SRC_INT) ||
      (src_ack_q == tcm_pkg::TCM_SRC_EXT && ext_rise);
   wire halted = debug_active && !ctrl_q.dbg_run;
   logic advance;
   wire adv = advance && enabled && !halted;
   wire at_mod = count_q == modulo_q;
   wire ovf_event = adv && at_mod;
   wire mod_xfer = mod_pend_q && (!enabled || (adv && at_mod));
   wire clr_ovf = (wr_ctrl && pwdata[tcm_pkg::TCM_CTRL_OVF_BIT]) || (wr && sel_clr && pwdata[0]);
   wire [1:0] src_shown = (ctrl_q.src == tcm_pkg::TCM_SRC_OFF) ? src_ack_q : ctrl_q.src;
   wire [31:0] ctrl_rd = {23'h000000, ctrl_q.dbg_run, ovf_q, ovf_ie_q, 1'b0, src_shown,
      ctrl_q.ps};
   wire [31:0] rd_mux = sel_ctrl ? ctrl_rd :
      sel_count ? {16'h0000, count_q} :
      sel_mod ? {16'h0000, modulo_q} :
      sel_st ? {31'h00000000, ovf_q} :
      sel_ie ? {31'h00000000, ovf_ie_q} : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////////////
   tcm_prescaler u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .clear(wr_count || !enabled),
      .tick(tick && !halted),
      .ps(ctrl_q.ps),
      .advance(advance)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // apb answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q <= 2'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         if (setup || pready) begin
            wait_q <= 2'h0;
         end else if (access && !pready) begin
            wait_q <= 2'(wait_q + 2'h1);
         end
         // pready is registered: answer one cycle after the access request is seen, two cycles more for count reads
         if (access && !pready &&
               (!slow_read || wait_q == 2'(tcm_pkg::TCM_COUNT_READ_WAITS))) begin
            pready <= 1'b1;
            pslverr <= !mapped;
            prdata <= pwrite ? 32'h00000000 : rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= '{src: tcm_pkg::TCM_SRC_OFF, ps: tcm_pkg::TCM_PS_RESET, dbg_run: 1'b0};
         ovf_ie_q <= 1'b0;
         src_ack_q <= tcm_pkg::TCM_SRC_OFF;
      end else begin
         if (wr_ctrl && pready) begin
            ctrl_q.src <= new_src;
            ctrl_q.dbg_run <= pwdata[tcm_pkg::TCM_CTRL_DBG_LSB];
            ovf_ie_q <= pwdata[6];
            if (!enabled && ctrl_q.src == tcm_pkg::TCM_SRC_OFF) begin
               ctrl_q.ps <= pwdata[tcm_pkg::TCM_CTRL_PS_LSB +: 3];
            end
         end
         if (wr && sel_ie && pready) begin
            ovf_ie_q <= pwdata[0];
         end
         src_ack_q <= (ctrl_q.src == tcm_pkg::TCM_SRC_RSVD) ? tcm_pkg::TCM_SRC_OFF : ctrl_q.src;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // external clock sync and counting path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
         count_q <= tcm_pkg::TCM_COUNT_RESET;
         modulo_q <= tcm_pkg::TCM_MODULO_RESET;
         mod_buf_q <= tcm_pkg::TCM_MODULO_RESET;
         mod_pend_q <= 1'b0;
         ovf_q <= 1'b0;
         irq <= 1'b0;
      end else begin
         ext_s1_q <= external_count_clock_input;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
         if (wr_count && pready) begin
            count_q <= tcm_pkg::TCM_COUNT_RESET;
         end else if (adv) begin
            count_q <= at_mod ? 16'h0000 : 16'(count_q + 16'h0001);
         end
         if (wr_mod && pready && !mod_pend_q) begin
            mod_buf_q <= pwdata[15:0];
            mod_pend_q <= 1'b1;
         end else if (mod_xfer) begin
            modulo_q <= mod_buf_q;
            mod_pend_q <= 1'b0;
         end
         if (ovf_event) begin
            ovf_q <= 1'b1;
         end else if (clr_ovf && pready) begin
            ovf_q <= 1'b0;
         end
         irq <= (ovf_q || ovf_event) && ovf_ie_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   property p_count_wait;
      @(posedge pclk) disable iff (!presetn)
      (setup && sel_count && !pwrite) |=> !pready [*3] ##1 pready;
   endproperty
   a_count_wait: assert property (p_count_wait) else $error("count read wait wrong");

   property p_count_clear;
      @(posedge pclk) disable iff (!presetn)
      (wr_count && pready) |=> count_q == 16'h0000;
   endproperty
   a_count_clear: assert property (p_count_clear) else $error("count not cleared");

   property p_wrap;
      @(posedge pclk) disable iff (!presetn)
      (ovf_event && !(wr_count && pready)) |=> count_q == 16'h0000 && ovf_q;
   endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap or flag");

   property p_hold_off;
      @(posedge pclk) disable iff (!presetn)
      (!enabled && !(wr_count && pready)) |=> $stable(count_q);
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("counts while off");

   property p_debug;
      @(posedge pclk) disable iff (!presetn)
      (halted && !(wr_count && pready)) |=> $stable(count_q);
   endproperty
   a_debug: assert property (p_debug) else $error("counts in debug");

   property p_ps_lock;
      @(posedge pclk) disable iff (!presetn)
      (enabled || ctrl_q.src != tcm_pkg::TCM_SRC_OFF) |=> $stable(ctrl_q.ps);
   endproperty
   a_ps_lock: assert property (p_ps_lock) else $error("prescale changed");

   property p_mod_ignore;
      @(posedge pclk) disable iff (!presetn)
      (mod_pend_q && !mod_xfer) |=> $stable(mod_buf_q);
   endproperty
   a_mod_ignore: assert property (p_mod_ignore) else $error("buffer overwritten");

   property p_ovf_sticky;
      @(posedge pclk) disable iff (!presetn)
      ovf_event |=> ovf_q;
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow lost");

   property p_upper_zero;
      @(posedge pclk) disable iff (!presetn)
      (pready && !pslverr && (sel_count || sel_mod)) |-> prdata[31:16] == 16'h0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

   c_wrap: cover property (@(posedge pclk) disable iff (!presetn) ovf_event);
   c_mod_load: cover property (@(posedge pclk) disable iff (!presetn) mod_xfer && enabled);
   c_ext: cover property (@(posedge pclk) disable iff (!presetn) adv && src_ack_q == 2'h2);
endmodule
`default_nettype wire

// >>> tcm_core_tb.sv
// testbench: apb driven checks of the modulo timer core
`timescale 1ns/1ps
`default_nettype none
module tcm_core_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic ext_clk = 1'b0;
   logic debug_active = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [31:0] rd_q;
   logic [31:0] first_q;
   logic err_q;
   int n_acc;
   int n_base;
   int mismatches = 0;
   int samples_checked = 0;

   always #20 pclk = ~pclk;

   tcm_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_count_clock_input(ext_clk),
      .debug_active(debug_active), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one apb transfer; read data, error and access edges left in globals
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n_acc = 0;
      do begin
         @(posedge pclk);
         n_acc++;
      end while (pready !== 1'b1 && n_acc < 50);
      if (pready !== 1'b1) begin
         mismatches++;
      end
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [31:0] ctl(input logic [1:0] s, input logic [2:0] p,
      input logic e, input logic g);
      ctl = (32'(s) << tcm_pkg::TCM_CTRL_SRC_LSB) | (32'(p) << tcm_pkg::TCM_CTRL_PS_LSB)
         | (32'(e) << 6) | (32'(g) << tcm_pkg::TCM_CTRL_DBG_LSB);
   endfunction

   // slow external edges, well above the synchronizer's needs
   task automatic ext(input int k);
      repeat (k) begin
         ext_clk <= 1'b1;
         repeat (4) @(posedge pclk);
         ext_clk <= 1'b0;
         repeat (4) @(posedge pclk);
      end
      repeat (6) @(posedge pclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      stop_test();
   end

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, tcm_pkg::TCM_OFS_CTRL, 32'h0);
      chk(rd_q, 32'h0000_0000);
      n_base = n_acc;
      apb(1'b0, tcm_pkg::TCM_OFS_COUNT, 32'h0);
      chk(rd_q, 32'h0000_0000);
      chk(32'(n_acc - n_base), 32'h0000_0002);
      apb(1'b0, tcm_pkg::TCM_OFS_MODULO, 32'h0);
      chk(rd_q, 32'h0000_FFFF);
      apb(1'b0, 12'h00C, 32'h0);
      chk(32'(err_q), 32'h0000_0001);
      // external source, divide by one then by four
      apb(1'b1, tcm_pkg::TCM_OFS_CTRL, ctl(tcm_pkg::TCM_SRC_EXT, 3'h0, 1'b0, 1'b0));
      ext(5);
      apb(1'b0, tcm_pkg::TCM_OFS_COUNT, 32'h0);
      chk(rd_q, 32'h0000_0005);
      apb(1'b1, tcm_pkg::TCM_OFS_CTRL, ctl(tcm_pkg::TCM_SRC_EXT, 3'h3, 1'b0, 1'b0));
      apb(1'b0, tcm_pkg::TCM_OFS_CTRL, 32'h0);
      chk(32'(rd_q[2:0]), 32'h0000_0000);
      apb(1'b1, tcm_pkg::TCM_OFS_CTRL, ctl(tcm_pkg::TCM_SRC_OFF, 3'h2, 1'b0, 1'b0));
      apb(1'b1, tcm_pkg::TCM_OFS_COUNT, 32'hFFFF_1234);
      apb(1'b0, tcm_pkg::TCM_OFS_COUNT, 32'h0);
      chk(rd_q, 32'h0000_0000);
      apb(1'b1, tcm_pkg::TCM_OFS_CTRL, ctl(tcm_pkg::TCM_SRC_EXT, 3'h2, 1'b0, 1'b0));
      ext(8);
      apb(1'b0, tcm_pkg::TCM_OFS_COUNT, 32'h0);
      chk(rd_q, 32'h0000_0002);
      // debug halt, then run in debug
      apb(1'b1, tcm_pkg::TCM_OFS_CTRL, 32'h0);
      apb(1'b1, tcm_pkg::TCM_OFS_CTRL, ctl(tcm_pkg::TCM_SRC_OFF, 3'h0, 1'b0, 1'b0));
      debug_active <= 1'b1;
      apb(1'b1, tcm_pkg::TCM_OFS_CTRL, ctl(tcm_pkg::TCM_SRC_INT, 3'h0, 1'b0, 1'b0));
      apb(1'b0, tcm_pkg::TCM_OFS_COUNT, 32'h0);
      first_q = rd_q;
      apb(1'b0, tcm_pkg::TCM_OFS_COUNT, 32'h0);
      chk(rd_q, first_q);
      apb(1'b1, tcm_pkg::TCM_OFS_CTRL, ctl(tcm_pkg::TCM_SRC_INT, 3'h0, 1'b0, 1'b1));
      apb(1'b0, tcm_pkg::TCM_OFS_COUNT, 32'h0);
      first_q = rd_q;
      apb(1'b0, tcm_pkg::TCM_OFS_COUNT, 32'h0);
      chk(32'(rd_q !== first_q), 32'h0000_0001);
      debug_active <= 1'b0;
      // held and reserved sources do not count
      for (int s = 0; s < 4; s += 3) begin
         apb(1'b1, tcm_pkg::TCM_OFS_CTRL, ctl(2'(s), 3'h0, 1'b0, 1'b0));
         apb(1'b0, tcm_pkg::TCM_OFS_COUNT, 32'h0);
         first_q = rd_q;
         apb(1'b0, tcm_pkg::TCM_OFS_COUNT, 32'h0);
         chk(rd_q, first_q);
      end
      // modulo, overflow and interrupt
      apb(1'b1, tcm_pkg::TCM_OFS_CTRL, 32'h0);
      apb(1'b1, tcm_pkg::TCM_OFS_COUNT, 32'h0);
      apb(1'b1, tcm_pkg::TCM_OFS_MODULO, 32'hABCD_0003);
      apb(1'b0, tcm_pkg::TCM_OFS_MODULO, 32'h0);
      chk(rd_q, 32'h0000_0003);
      apb(1'b1, tcm_pkg::TCM_OFS_CTRL, ctl(tcm_pkg::TCM_SRC_INT, 3'h0, 1'b1, 1'b0));
      repeat (20) @(posedge pclk);
      chk(32'(irq), 32'h0000_0001);
      apb(1'b0, tcm_pkg::TCM_OFS_COUNT, 32'h0);
      chk(32'(rd_q <= 32'h3), 32'h0000_0001);
      // halt in debug so the buffer stays pending across both writes
      debug_active <= 1'b1;
      apb(1'b1, tcm_pkg::TCM_OFS_MODULO, 32'h0000_0009);
      apb(1'b1, tcm_pkg::TCM_OFS_MODULO, 32'h0000_0007);
      apb(1'b0, tcm_pkg::TCM_OFS_MODULO, 32'h0);
      chk(rd_q, 32'h0000_0003);
      debug_active <= 1'b0;
      repeat (40) @(posedge pclk);
      apb(1'b0, tcm_pkg::TCM_OFS_MODULO, 32'h0);
      chk(rd_q, 32'h0000_0009);
      apb(1'b1, tcm_pkg::TCM_OFS_CTRL, ctl(tcm_pkg::TCM_SRC_OFF, 3'h0, 1'b1, 1'b0));
      apb(1'b1, tcm_pkg::TCM_OFS_IRQ_ENABLE, 32'h0);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h0000_0000);
      apb(1'b1, tcm_pkg::TCM_OFS_IRQ_ENABLE, 32'h1);
      apb(1'b1, tcm_pkg::TCM_OFS_IRQ_CLEAR, 32'h0);
      apb(1'b0, tcm_pkg::TCM_OFS_IRQ_STATUS, 32'h0);
      chk(rd_q, 32'h0000_0001);
      chk(32'(irq), 32'h0000_0001);
      apb(1'b1, tcm_pkg::TCM_OFS_IRQ_CLEAR, 32'h1);
      apb(1'b0, tcm_pkg::TCM_OFS_IRQ_STATUS, 32'h0);
      chk(rd_q, 32'h0000_0000);
      chk(32'(irq), 32'h0000_0000);
      stop_test();
   end
endmodule
`default_nettype wire
